// >>> rtl/tfcr_regs.sv
// Register slice: fault thresholds, clock-recovery control, converter result
// Assumes APB master on pclk; analog side gives synchronous measurements
//
// Behaviour
// - Digital bias monitor selected: fault when bias current reaches threshold.
// - Digital photodiode monitor selected: fault when current reaches threshold.
// - Mode field: 00 auto, 01 fixed 10.3G, 10 fixed 11.1G, 11 test.
// - Force-on bit keeps the frequency detector enabled unless the force-off bit is set.
// - Force-off bit keeps the frequency detector always disabled.
// - Fast-lock-off bit set disables fast acquisition; cleared enables it.
// - Converter result: bits 9:2 in high register, 1:0 in low.
// - Registers 20 to 39 read zero, writes ignored.
// - Threshold and detector control registers read/write, reset zero.
// - Bias select bit 1 digital monitor, 0 analog with resistor.
// - Photodiode select bit 1 digital monitor, 0 analog with resistor.
//
// Design decision made here: register access over APB.
`include "tfcr_defs.svh"
module tfcr_regs (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurements
  input wire logic [7:0] bias_meas,
  input wire logic [7:0] pd_meas,
  input wire logic [9:0] adc_result,
  input wire logic adc_valid,
  // Controls to analog and clock recovery
  output tfcr_pkg::tfcr_cdr_ctrl_s cdr_ctrl,
  output logic digital_bias_monitor_sel,
  output logic digital_pd_monitor_sel,
  output logic tx_fault,
  output logic irq
);
  logic [7:0] bias_fault_level_q;
  logic [7:0] power_fault_level_q;
  logic [7:0] fd_ctrl_q;
  logic [7:0] mon_sel_q;
  logic [9:0] adc_q;
  logic [7:0] rx_rsvd_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic tx_fault_q;
  logic [31:0] prdata_q;
  logic [7:0] idx;
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  logic bias_flt;
  logic pwr_flt;
  logic [7:0] rdata;
  logic [2:0] div_code;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; single-cycle answer, errors on unmapped index
  assign idx = paddr[9:2];
  assign acc = psel && penable && clk_en;
  assign wr = acc && pwrite && pstrb[0];
  assign rd = acc && !pwrite;
  assign pready = 1'b1;

  // Mapped check
  always_comb
  begin
    hit = 1'b1;
    case (idx)
      `TFCR_IDX_BIAS_THR, `TFCR_IDX_PWR_THR, `TFCR_IDX_FD_CTRL,
      `TFCR_IDX_ADC_HI, `TFCR_IDX_ADC_LO, `TFCR_IDX_RX_RSVD,
      `TFCR_IDX_MON_SEL, `TFCR_IDX_IRQ_STAT, `TFCR_IDX_IRQ_MASK: hit = 1'b1;
      default: hit = (idx >= `TFCR_IDX_RSVD_LO) && (idx <= `TFCR_IDX_RSVD_HI);
    endcase
  end
  assign pslverr = psel && penable && !(hit && paddr[11:10] == 2'b00);

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers, reset to zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bias_fault_level_q <= `TFCR_RESET_VAL;
      power_fault_level_q <= `TFCR_RESET_VAL;
      fd_ctrl_q <= `TFCR_RESET_VAL;
      mon_sel_q <= `TFCR_RESET_VAL;
      irq_mask_q <= 2'h0;
    end
    else if (wr && !pslverr)
    begin
      // Reserved and read-only indices fall through untouched
      case (idx)
        `TFCR_IDX_BIAS_THR: bias_fault_level_q <= pwdata[7:0];
        `TFCR_IDX_PWR_THR: power_fault_level_q <= pwdata[7:0];
        `TFCR_IDX_FD_CTRL: fd_ctrl_q <= pwdata[7:0];
        `TFCR_IDX_MON_SEL: mon_sel_q <= pwdata[7:0];
        `TFCR_IDX_IRQ_MASK: irq_mask_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor selection and fault comparison
  assign digital_bias_monitor_sel = mon_sel_q[`TFCR_DBIAS_SEL_BIT];
  assign digital_pd_monitor_sel = mon_sel_q[`TFCR_DPD_SEL_BIT];
  assign bias_flt = digital_bias_monitor_sel &&
                    (bias_meas >= bias_fault_level_q);
  assign pwr_flt = digital_pd_monitor_sel &&
                   (pd_meas >= power_fault_level_q);

  // Registered fault output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_fault_q <= 1'b0;
    else if (clk_en)
      tx_fault_q <= bias_flt || pwr_flt;
  end
  assign tx_fault = tx_fault_q;

  ////////////////////////////////////////////////////////////////////////////
  // Clock-recovery controls
  assign div_code = fd_ctrl_q[`TFCR_DIV_HI:0];
  always_comb
  begin
    cdr_ctrl.freq_detect_mode = tfcr_pkg::tfcr_fd_mode_e'(
      fd_ctrl_q[`TFCR_FD_MODE_HI:`TFCR_FD_MODE_LO]);
    // Force-off has precedence over force-on; else automatic
    if (fd_ctrl_q[`TFCR_FD_OFF_BIT])
      cdr_ctrl.freq_detect_enable = 1'b0;
    else if (fd_ctrl_q[`TFCR_FD_ON_BIT])
      cdr_ctrl.freq_detect_enable = 1'b1;
    else
      cdr_ctrl.freq_detect_enable =
        (cdr_ctrl.freq_detect_mode == tfcr_pkg::TFCR_FD_AUTO);
    cdr_ctrl.fast_lock_on = !fd_ctrl_q[`TFCR_FL_OFF_BIT];
    // Index 0 of the one-hot is divide by 2; all zero is full rate
    case (div_code)
      3'h0: cdr_ctrl.rate_divide_onehot = 6'h00;
      3'h1: cdr_ctrl.rate_divide_onehot = 6'h01;
      3'h2: cdr_ctrl.rate_divide_onehot = 6'h02;
      3'h3: cdr_ctrl.rate_divide_onehot = 6'h04;
      3'h4: cdr_ctrl.rate_divide_onehot = 6'h08;
      3'h5: cdr_ctrl.rate_divide_onehot = 6'h10;
      default: cdr_ctrl.rate_divide_onehot = 6'h20;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter result capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      adc_q <= 10'h000;
    else if (clk_en && adc_valid)
      adc_q <= adc_result;
  end

  // Reserved receive register; read-clear bits never set here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_rsvd_q <= `TFCR_RESET_VAL;
    else if (rd && !pslverr && idx == `TFCR_IDX_RX_RSVD)
      rx_rsvd_q <= rx_rsvd_q & ~`TFCR_RC_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, cleared on read; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= 2'h0;
    else if (clk_en)
    begin
      // Clear only bits already latched into the read data
      if (rd && !pslverr && idx == `TFCR_IDX_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~prdata_q[1:0]) | {pwr_flt, bias_flt};
      else
        irq_stat_q <= irq_stat_q | {pwr_flt, bias_flt};
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb
  begin
    rdata = 8'h00;
    case (idx)
      `TFCR_IDX_BIAS_THR: rdata = bias_fault_level_q;
      `TFCR_IDX_PWR_THR: rdata = power_fault_level_q;
      `TFCR_IDX_FD_CTRL: rdata = fd_ctrl_q;
      `TFCR_IDX_ADC_HI: rdata = adc_q[9:2];
      `TFCR_IDX_ADC_LO: rdata = {6'h00, adc_q[1:0]};
      `TFCR_IDX_RX_RSVD: rdata = rx_rsvd_q;
      `TFCR_IDX_MON_SEL: rdata = mon_sel_q;
      `TFCR_IDX_IRQ_STAT: rdata = {6'h00, irq_stat_q};
      `TFCR_IDX_IRQ_MASK: rdata = {6'h00, irq_mask_q};
      default: rdata = 8'h00;
    endcase
  end

  // Read data register, updated at the setup-phase edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite && clk_en)
      prdata_q <= {24'h00_0000, rdata};
  end
  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Faults follow a selected digital monitor one cycle later
  AST_BIAS_FAULT: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && digital_bias_monitor_sel && bias_meas >= bias_fault_level_q
    |=> tx_fault)
    else $error("bias fault not raised");
  AST_PWR_FAULT: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && digital_pd_monitor_sel && pd_meas >= power_fault_level_q
    |=> tx_fault)
    else $error("power fault not raised");
  AST_NO_FAULT: assert property (@(posedge pclk)
    disable iff (!presetn)
    clk_en && !(digital_bias_monitor_sel && bias_meas >= bias_fault_level_q)
    && !(digital_pd_monitor_sel && pd_meas >= power_fault_level_q)
    |=> !tx_fault)
    else $error("spurious fault");
  // Detector control decode
  AST_FORCE_OFF: assert property (@(posedge pclk)
    disable iff (!presetn)
    fd_ctrl_q[`TFCR_FD_OFF_BIT] |-> !cdr_ctrl.freq_detect_enable)
    else $error("force off ignored");
  AST_FORCE_ON: assert property (@(posedge pclk)
    disable iff (!presetn)
    fd_ctrl_q[`TFCR_FD_ON_BIT] && !fd_ctrl_q[`TFCR_FD_OFF_BIT]
    |-> cdr_ctrl.freq_detect_enable)
    else $error("force on ignored");
  AST_FD_AUTO: assert property (@(posedge pclk)
    disable iff (!presetn)
    !fd_ctrl_q[`TFCR_FD_ON_BIT] && !fd_ctrl_q[`TFCR_FD_OFF_BIT]
    |-> cdr_ctrl.freq_detect_enable ==
        (fd_ctrl_q[`TFCR_FD_MODE_HI:`TFCR_FD_MODE_LO] == 2'h0))
    else $error("automatic detector control wrong");
  AST_FD_MODE: assert property (@(posedge pclk)
    disable iff (!presetn)
    cdr_ctrl.freq_detect_mode == fd_ctrl_q[`TFCR_FD_MODE_HI:`TFCR_FD_MODE_LO])
    else $error("mode field not passed on");
  AST_FAST_LOCK: assert property (@(posedge pclk)
    disable iff (!presetn)
    cdr_ctrl.fast_lock_on != fd_ctrl_q[`TFCR_FL_OFF_BIT])
    else $error("fast lock wrong");
  AST_DIV: assert property (@(posedge pclk)
    disable iff (!presetn)
    div_code == 3'h0 |-> cdr_ctrl.rate_divide_onehot == 6'h00)
    else $error("full rate wrong");
  AST_DIV_MAP: assert property (@(posedge pclk)
    disable iff (!presetn)
    div_code != 3'h0 && div_code <= 3'h5
    |-> cdr_ctrl.rate_divide_onehot == (6'h01 << (div_code - 3'h1)))
    else $error("divider select wrong");
  // Register writes
  AST_THR_WRITE: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr && !pslverr && idx == `TFCR_IDX_BIAS_THR
    |=> bias_fault_level_q == $past(pwdata[7:0]))
    else $error("threshold write lost");
  AST_PWR_WRITE: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr && !pslverr && idx == `TFCR_IDX_PWR_THR
    |=> power_fault_level_q == $past(pwdata[7:0]))
    else $error("power threshold write lost");
  AST_RSVD_NOWRITE: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr && idx >= `TFCR_IDX_RSVD_LO && idx <= `TFCR_IDX_RSVD_HI
    |=> $stable({bias_fault_level_q, power_fault_level_q, fd_ctrl_q,
                 mon_sel_q, irq_mask_q}))
    else $error("reserved write changed a register");
  // Read data
  AST_RSVD_ZERO: assert property (@(posedge pclk)
    disable iff (!presetn)
    psel && !penable && !pwrite && clk_en &&
    idx >= `TFCR_IDX_RSVD_LO && idx <= `TFCR_IDX_RSVD_HI
    |=> prdata == 32'h0000_0000)
    else $error("reserved not zero");
  AST_ADC_HI: assert property (@(posedge pclk)
    disable iff (!presetn)
    psel && !penable && !pwrite && clk_en && idx == `TFCR_IDX_ADC_HI
    |=> prdata == {24'h00_0000, $past(adc_q[9:2])})
    else $error("adc high bits wrong");
  AST_ADC_LO: assert property (@(posedge pclk)
    disable iff (!presetn)
    psel && !penable && !pwrite && clk_en && idx == `TFCR_IDX_ADC_LO
    |=> prdata[31:2] == 30'h0000_0000)
    else $error("adc low upper bits set");
  AST_RX_ZERO: assert property (@(posedge pclk)
    disable iff (!presetn)
    psel && !penable && !pwrite && clk_en && idx == `TFCR_IDX_RX_RSVD
    |=> prdata == 32'h0000_0000)
    else $error("receive reserved not zero");
  // Main scenarios
  COV_FAULT: cover property (@(posedge pclk) disable iff (!presetn)
    !tx_fault ##1 tx_fault);
  COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) irq);
  COV_BOTH_FORCE: cover property (@(posedge pclk) disable iff (!presetn)
    fd_ctrl_q[`TFCR_FD_ON_BIT] && fd_ctrl_q[`TFCR_FD_OFF_BIT]);
  COV_STAT_CLEAR: cover property (@(posedge pclk) disable iff (!presetn)
    rd && idx == `TFCR_IDX_IRQ_STAT && irq_stat_q != 2'h0);
  COV_FREEZE: cover property (@(posedge pclk) disable iff (!presetn)
    !clk_en && (bias_flt || pwr_flt));
endmodule

// >>> include/tfcr_defs.svh
// Register offsets, field positions and reset values of the register slice
// Assumes APB byte addressing, one 32-bit word per register index
`ifndef TFCR_DEFS_SVH
`define TFCR_DEFS_SVH
// Register indices; byte address is four times the index
`define TFCR_IDX_BIAS_THR 8'h11
`define TFCR_IDX_PWR_THR 8'h12
`define TFCR_IDX_FD_CTRL 8'h13
`define TFCR_IDX_RSVD_LO 8'h14
`define TFCR_IDX_RSVD_HI 8'h27
`define TFCR_IDX_ADC_HI 8'h28
`define TFCR_IDX_ADC_LO 8'h29
`define TFCR_IDX_RX_RSVD 8'h2a
`define TFCR_IDX_MON_SEL 8'h30
`define TFCR_IDX_IRQ_STAT 8'h31
`define TFCR_IDX_IRQ_MASK 8'h32
// Field positions of the detector control register
`define TFCR_FD_MODE_HI 7
`define TFCR_FD_MODE_LO 6
`define TFCR_FD_ON_BIT 5
`define TFCR_FD_OFF_BIT 4
`define TFCR_FL_OFF_BIT 3
`define TFCR_DIV_HI 2
// Field positions of the monitor select register
`define TFCR_DPD_SEL_BIT 6
`define TFCR_DBIAS_SEL_BIT 5
// Status bits: bias fault, power fault
`define TFCR_ST_BIAS 0
`define TFCR_ST_PWR 1
// Read-clear bits of the reserved receive register
`define TFCR_RC_MASK 8'h50
`define TFCR_RESET_VAL 8'h00
`endif

// >>> include/tfcr_pkg.sv
// Types shared by the register slice
// Assumes the defs header holds all numbers
package tfcr_pkg;
  typedef enum logic [1:0] {
    TFCR_FD_AUTO = 2'b00,
    TFCR_FD_10G3 = 2'b01,
    TFCR_FD_11G1 = 2'b10,
    TFCR_FD_TEST = 2'b11
  } tfcr_fd_mode_e;
  typedef struct packed {
    tfcr_fd_mode_e freq_detect_mode;
    logic freq_detect_enable;
    logic fast_lock_on;
    logic [5:0] rate_divide_onehot;
  } tfcr_cdr_ctrl_s;
endpackage

// >>> bench/tfcr_apb_host.sv
// APB requester model standing in for the module microcontroller
// Assumes one clock; pready sampled at rising edges only
module tfcr_apb_host (
  // Clock
  input wire logic pclk,
  // APB requester outputs
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // Completion
  input wire logic pready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  // One transfer: setup, access until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse, never a stale copy
    paddr <= ~a;
    pwdata <= ~d;
    pwrite <= ~w;
  endtask
endmodule

// >>> bench/tb.sv
// Self-checking bench of the register slice
// Assumes the APB host model and the package are compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, tx_fault, irq, sb, sp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] bias_meas = 8'h00;
  logic [7:0] pd_meas = 8'h00;
  logic [9:0] adc_result = 10'h000;
  logic adc_valid = 1'b0;
  logic clk_en = 1'b1;
  tfcr_pkg::tfcr_cdr_ctrl_s cdr_ctrl;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 99052;
  logic [32:0] expq[$];
  logic [7:0] t_b, t_p, v;
  logic [9:0] r, ex;
  logic [1:0] m;
  logic [2:0] c;
  logic [11:0] ra[6] = '{12'h044, 12'h048, 12'h04c, 12'h0a0, 12'h0a4,
                         12'h0a8};
  ////////////////////////////////////////////////////////////////////////
  // Clock
  always #5 pclk = ~pclk;
  tfcr_apb_host u_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready));
  tfcr_regs u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bias_meas(bias_meas), .pd_meas(pd_meas),
    .adc_result(adc_result), .adc_valid(adc_valid), .cdr_ctrl(cdr_ctrl),
    .digital_bias_monitor_sel(sb), .digital_pd_monitor_sel(sp),
    .tx_fault(tx_fault), .irq(irq));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] d, logic e);
    expq.push_back({e, d});
    u_host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic meas(logic [7:0] b, logic [7:0] p);
    @(posedge pclk);
    bias_meas <= b;
    pd_meas <= p;
    repeat (3) @(negedge pclk);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Read monitor: oldest note against data seen at the access edge
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && expq.size() > 0)
    begin
      chk("prdata", expq[0][31:0], prdata);
      chk("pslverr", {31'h0, expq[0][32]}, {31'h0, pslverr});
      void'(expq.pop_front());
    end
  // Watchdog
  initial
  begin
    #200us;
    n_errors++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("cdr", 32'h0c0, {22'h0, cdr_ctrl});
    chk("fault", 32'h0, {31'h0, tx_fault});
    foreach (ra[i])
      rd(ra[i], 32'h0, 1'b0);
    t_b = 8'h80 | 8'($random(seed));
    t_p = 8'h80 | 8'($random(seed));
    wr(12'h044, {24'h0, t_b});
    wr(12'h048, {24'h0, t_p});
    rd(12'h044, {24'h0, t_b}, 1'b0);
    rd(12'h048, {24'h0, t_p}, 1'b0);
    for (int i = 8'h14; i <= 8'h2a; i++)
    begin
      wr(12'(i * 4), $random(seed));
      rd(12'(i * 4), 32'h0, 1'b0);
    end
    rd(12'h200, 32'h0, 1'b1);
    r = 10'($random(seed));
    adc_result <= r;
    adc_valid <= 1'b1;
    @(posedge pclk);
    adc_valid <= 1'b0;
    adc_result <= ~r;
    rd(12'h0a0, {24'h0, r[9:2]}, 1'b0);
    rd(12'h0a4, {30'h0, r[1:0]}, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      m = 2'(k % 3);
      c = 3'(k + 3);
      v = {m, k[0], k[1], k[2], c};
      ex = {m, k[1] ? 1'b0 : (k[0] | (m == 2'b00)), ~k[2],
            c == 3'h0 ? 6'h00 : (c > 3'h5 ? 6'h20 : 6'h01 << (c - 3'h1))};
      wr(12'h04c, {24'h0, v});
      @(negedge pclk);
      chk("cdr", {22'h0, ex}, {22'h0, cdr_ctrl});
      rd(12'h04c, {24'h0, v}, 1'b0);
    end
    wr(12'h0c0, 32'h60);
    @(negedge pclk);
    chk("sel", 32'h3, {30'h0, sp, sb});
    meas(t_b - 8'h01, 8'h00);
    chk("fault", 32'h0, {31'h0, tx_fault});
    meas(t_b, 8'h00);
    chk("fault", 32'h1, {31'h0, tx_fault});
    chk("irq", 32'h0, {31'h0, irq});
    wr(12'h0c8, 32'h3);
    @(negedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    meas(8'h00, t_p);
    chk("fault", 32'h1, {31'h0, tx_fault});
    meas(8'h00, 8'h00);
    chk("fault", 32'h0, {31'h0, tx_fault});
    rd(12'h0c4, 32'h3, 1'b0);
    rd(12'h0c4, 32'h0, 1'b0);
    @(negedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    // Clock enable low: no fault taken, no status set
    @(posedge pclk);
    clk_en <= 1'b0;
    bias_meas <= t_b;
    repeat (3) @(negedge pclk);
    chk("frozen fault", 32'h0, {31'h0, tx_fault});
    chk("frozen irq", 32'h0, {31'h0, irq});
    @(posedge pclk);
    clk_en <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("fault", 32'h1, {31'h0, tx_fault});
    chk("irq", 32'h1, {31'h0, irq});
    // Reset in mid-run: every register back to zero
    @(posedge pclk);
    presetn <= 1'b0;
    bias_meas <= 8'h00;
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("fault", 32'h0, {31'h0, tx_fault});
    chk("irq", 32'h0, {31'h0, irq});
    chk("cdr", 32'h0c0, {22'h0, cdr_ctrl});
    rd(12'h044, 32'h0, 1'b0);
    rd(12'h04c, 32'h0, 1'b0);
    rd(12'h0c0, 32'h0, 1'b0);
    @(negedge pclk);
    chk("pending", 32'h0, 32'(expq.size()));
    finish_test();
  end
endmodule
